//--- inc/tpmp_pkg.sv
// Constants shared by the transmit mapping packer files
package tpmp_pkg;
   // ***************************************************
   // Build-time sizes
   // ***************************************************
   localparam int NUM_TPDO = 4; // Frames supported, fixed at build
   localparam int FR_W = 2; // Frame number width
   localparam int NUM_REFS = 8; // References per table
   localparam int REF_W = 3; // Reference slot index width
   localparam int DATA_BITS = 64; // Frame data field size
   localparam int BUF_DEPTH = 2; // Output buffer entries
   localparam int PAY_W = FR_W + 4 + 16 + DATA_BITS; // Buffer word
   // ***************************************************
   // Object index space of the mapping tables
   // ***************************************************
   localparam logic [15:0] MAP_BASE_INDEX = 16'h1A00; // Frame 1 table
   localparam logic [15:0] MAP_LAST_INDEX = 16'h1BFF; // Last legal
   // ***************************************************
   // Reference word layout
   // ***************************************************
   localparam int REF_IDX_LSB = 16; // Object index, 16 bits
   localparam int REF_SUB_LSB = 8; // Sub-index, 8 bits
   localparam int REF_LEN_LSB = 0; // Length in bits, 8 bits
   localparam logic [7:0] MAX_VAL_BITS = 8'h20; // Value port width
   // ***************************************************
   // Register map, byte addresses
   // ***************************************************
   localparam int ADDR_W = 10; // Byte address width
   localparam logic [1:0] TBL_REGION = 2'h0; // Address bits 9:8
   localparam logic [3:0] LAST_SUB = 4'h8; // Highest table entry
   localparam logic [9:0] CTRL_ADDR = 10'h200; // Control
   localparam logic [9:0] STAT_ADDR = 10'h204; // Status, W1C
   localparam logic [9:0] SENT_ADDR = 10'h208; // Frames sent
   localparam int CTRL_EN_BIT = 0; // Transmit enable
   localparam logic CTRL_RESET = 1'b0; // Disabled after reset
   localparam int ST_BUSY = 0; // Packing in progress
   localparam int ST_UNMAP = 1; // Non-mappable object met
   localparam int ST_LEN = 2; // Bad length or over 8 bytes
   localparam int ST_CNT = 3; // Count above eight
   localparam int ST_SUPP = 4; // Frame suppressed, count zero
endpackage

//--- hdl/tpmp_skid_buf.sv
// Two-entry skid buffer between packer and frame sink
`timescale 1ns/100ps
`default_nettype none
module tpmp_skid_buf #(
   parameter int W = 8 // Payload width
) (
   input wire logic core_clk, // System clock
   input wire logic rst_n, // Synchronous reset, active low
   input wire logic in_valid, // Word offered
   output logic in_ready, // Room for a word
   input wire logic [W-1:0] in_data, // Word offered
   output logic out_valid, // Word held at output
   input wire logic out_ready, // Sink takes word
   output logic [W-1:0] out_data // Word held at output
);
   logic [W-1:0] skid_q; // Second entry
   logic skid_v_q; // Second entry holds a word
   // Ready only from a flop, so no path from sink to source
   assign in_ready = ~skid_v_q;
   // ***************************************************
   // Entry movement
   // ***************************************************
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         out_valid <= 1'b0;
         skid_v_q <= 1'b0;
         out_data <= '0;
         skid_q <= '0;
      end else if (out_ready || !out_valid) begin
         // Output slot frees: refill from skid first
         if (skid_v_q) begin
            out_data <= skid_q;
            skid_v_q <= 1'b0;
         end else begin
            out_valid <= in_valid;
            if (in_valid) begin
               out_data <= in_data;
            end
         end
      end else if (in_valid && in_ready) begin
         // Sink stalled: park the word
         skid_q <= in_data;
         skid_v_q <= 1'b1;
      end
   end
endmodule
`default_nettype wire

//--- hdl/tpmp_insert.sv
// Places one mapped value into the frame data field
`timescale 1ns/100ps
`default_nettype none
module tpmp_insert (
   input wire logic [63:0] acc, // Data field so far
   input wire logic [31:0] value, // Object value, low bits used
   input wire logic [6:0] pos, // First free bit
   input wire logic [7:0] len, // Value length in bits
   output logic [63:0] acc_o // Data field with value added
);
   logic [63:0] mask; // Ones for the value's bits
   logic [63:0] wide; // Value cut and widened
   // Length already checked to 1..32 by the caller
   assign mask = (len >= 8'h20) ? 64'h00000000FFFFFFFF :
                 ((64'h1 << len[5:0]) - 64'h1);
   assign wide = {32'h0, value} & mask;
   assign acc_o = acc | (wide << pos[5:0]);
endmodule
`default_nettype wire

//--- hdl/tpmp_top.sv
// Transmit frame packer with mapping tables on Avalon-MM
// Notes on behaviour
// - frame k uses table 1A00 plus k-1
// - all tables lie within 1A00h to 1BFFh
// - number of frames fixed at build time
// - table holds count plus eight references
// - count says how many references are carried
// - count zero suppresses the frame
// - reference: index 16, sub 8, length 8
// - first value starts at byte zero
// - value size follows the reference's length field
// - later values follow the previous directly
// - references beyond the count are ignored
// - only mappable objects may be referenced
`timescale 1ns/100ps
`default_nettype none
module tpmp_top (
   input wire logic core_clk, // 100 MHz system clock
   input wire logic rst_n, // Synchronous reset, active low
   input wire logic [9:0] av_address, // Avalon byte address
   input wire logic av_read, // Avalon read
   input wire logic av_write, // Avalon write
   input wire logic [31:0] av_writedata, // Avalon write data
   input wire logic [3:0] av_byteenable, // Avalon byte lanes
   output logic [31:0] av_readdata, // Avalon read data
   output logic av_waitrequest, // Avalon stall
   input wire logic trig_valid, // Send request
   input wire logic [1:0] trig_frame, // Frame number minus one
   output logic trig_ready, // Packer idle, takes request
   output logic od_req, // Object value request
   output logic [15:0] od_index, // Requested object index
   output logic [7:0] od_sub, // Requested sub-index
   input wire logic od_ack, // Object value answer
   input wire logic [31:0] od_value, // Object value
   input wire logic od_mappable, // Object may be mapped
   output logic out_valid, // Packed frame ready
   input wire logic out_ready, // Sink takes frame
   output logic [1:0] out_frame, // Frame number minus one
   output logic [15:0] out_map_index, // Table index used
   output logic [3:0] out_dlc, // Data length code
   output logic [63:0] out_data // Data field, byte 0 low
);
   // ***************************************************
   // Helpers
   // ***************************************************
   // Reference word fields
   function automatic logic [7:0] ref_len(input logic [31:0] r);
      ref_len = r[tpmp_pkg::REF_LEN_LSB +: 8];
   endfunction
   function automatic logic [7:0] ref_sub(input logic [31:0] r);
      ref_sub = r[tpmp_pkg::REF_SUB_LSB +: 8];
   endfunction
   function automatic logic [15:0] ref_idx(input logic [31:0] r);
      ref_idx = r[tpmp_pkg::REF_IDX_LSB +: 16];
   endfunction
   // Byte-lane merge of a write into a stored word
   function automatic logic [31:0] merge(input logic [31:0] o,
                                         input logic [31:0] n,
                                         input logic [3:0] be);
      merge = o;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            merge[8*i +: 8] = n[8*i +: 8];
         end
      end
   endfunction
   // ***************************************************
   // Declarations
   // ***************************************************
   typedef enum logic [1:0] {
      S_IDLE, S_FETCH, S_WAIT, S_PUSH
   } tpmp_state_type;
   tpmp_state_type state_q, state_d; // Packer state
   logic [7:0] count_q [tpmp_pkg::NUM_TPDO]; // Count entries
   logic [31:0] ref_q [tpmp_pkg::NUM_TPDO * tpmp_pkg::NUM_REFS];
   logic ctrl_en_q; // Transmit enable
   logic [4:1] stat_q; // Sticky status flags
   logic [4:1] stat_set; // Hardware set pulses
   logic [15:0] sent_q; // Frames handed to buffer
   logic [31:0] rdata_q; // Read data hold
   logic wait_q; // Waitrequest
   logic [1:0] frame_q, frame_d; // Frame being packed
   logic [2:0] refn_q, refn_d; // Current reference slot
   logic [6:0] pos_q, pos_d; // Next free bit
   logic [63:0] acc_q, acc_d; // Data field being built
   logic od_req_q, od_req_d; // Value request
   logic [15:0] od_idx_q, od_idx_d; // Requested index
   logic [7:0] od_sub_q, od_sub_d; // Requested sub-index
   logic trig_rdy_q; // Idle flag for request port
   logic [63:0] ins_acc; // Data field with next value
   logic buf_in_ready; // Buffer has room
   // ***************************************************
   // Register decode
   // ***************************************************
   wire acc_req = av_read | av_write; // Any request
   wire commit = av_write & ~wait_q; // Write takes effect now
   wire is_tbl = (av_address[9:8] == tpmp_pkg::TBL_REGION);
   wire [1:0] a_fr = av_address[7:6]; // Table frame
   wire [3:0] a_sub = av_address[5:2]; // Table entry
   wire [3:0] a_subm = a_sub - 4'h1; // Reference slot
   wire sub_ok = (a_sub <= tpmp_pkg::LAST_SUB);
   wire [4:0] a_ref = {a_fr, a_subm[2:0]}; // Flat slot index
   wire wr_cnt = commit & is_tbl & (a_sub == 4'h0);
   wire wr_ref = commit & is_tbl & sub_ok & (a_sub != 4'h0);
   wire wr_ctrl = commit & (av_address == tpmp_pkg::CTRL_ADDR);
   wire wr_stat = commit & (av_address == tpmp_pkg::STAT_ADDR);
   wire [4:1] stat_clr = wr_stat ? (av_writedata[4:1] &
                         {4{av_byteenable[0]}}) : 4'h0;
   wire busy = (state_q != S_IDLE); // Packing under way
   wire [31:0] stat_word = {27'h0, stat_q, busy};
   wire [31:0] tbl_word = (a_sub == 4'h0) ?
                          {24'h0, count_q[a_fr]} : ref_q[a_ref];
   // Unmapped addresses read zero and ignore writes
   wire [31:0] rd_mux =
      (is_tbl && sub_ok) ? tbl_word :
      (av_address == tpmp_pkg::CTRL_ADDR) ? {31'h0, ctrl_en_q} :
      (av_address == tpmp_pkg::STAT_ADDR) ? stat_word :
      (av_address == tpmp_pkg::SENT_ADDR) ? {16'h0, sent_q} :
      32'h0;
   // ***************************************************
   // Avalon handshake
   // ***************************************************
   // One stall cycle per access, then one cycle low
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         wait_q <= 1'b1;
         rdata_q <= 32'h0;
      end else if (acc_req && wait_q) begin
         wait_q <= 1'b0;
         rdata_q <= rd_mux;
      end else begin
         wait_q <= 1'b1;
      end
   end
   // ***************************************************
   // Mapping tables
   // ***************************************************
   // Tables stay writable while packing; the master must stop
   // transmission first or a frame may mix old and new entries
   genvar gf, gr;
   generate
      for (gf = 0; gf < tpmp_pkg::NUM_TPDO; gf++) begin : g_fr
         // Count entry, low byte lane only
         always_ff @(posedge core_clk) begin
            if (!rst_n) begin
               count_q[gf] <= 8'h00;
            end else if (wr_cnt && a_fr == gf &&
                         av_byteenable[0]) begin
               count_q[gf] <= av_writedata[7:0];
            end
         end
         for (gr = 0; gr < tpmp_pkg::NUM_REFS; gr++) begin : g_rf
            // Reference entry, byte lanes honoured
            always_ff @(posedge core_clk) begin
               if (!rst_n) begin
                  ref_q[gf*8+gr] <= 32'h0;
               end else if (wr_ref && a_ref == gf*8+gr) begin
                  ref_q[gf*8+gr] <= merge(ref_q[gf*8+gr],
                                     av_writedata, av_byteenable);
               end
            end
         end
      end
   endgenerate
   // ***************************************************
   // Control, status and counter
   // ***************************************************
   // A flag set in the clearing cycle survives
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         ctrl_en_q <= tpmp_pkg::CTRL_RESET;
         stat_q <= 4'h0;
         sent_q <= 16'h0;
      end else begin
         if (wr_ctrl && av_byteenable[0]) begin
            ctrl_en_q <= av_writedata[tpmp_pkg::CTRL_EN_BIT];
         end
         stat_q <= stat_set | (stat_q & ~stat_clr);
         if (state_q == S_PUSH && buf_in_ready) begin
            sent_q <= sent_q + 16'h1;
         end
      end
   end
   // ***************************************************
   // Packer sequence
   // ***************************************************
   wire [31:0] cur_ref = ref_q[{frame_q, refn_q}]; // Slot in use
   wire [7:0] cur_len = ref_len(cur_ref); // Its length
   wire [7:0] end_bit = {1'b0, pos_q} + cur_len; // Bit after it
   wire [7:0] trig_cnt = count_q[trig_frame]; // Requested count
   wire [2:0] refn_inc = refn_q + 3'h1; // Next slot
   wire last_ref = ({5'h0, refn_q} + 8'h01 == count_q[frame_q]);
   wire [7:0] dlc_sum = {1'b0, pos_q} + 8'h07; // Round up
   wire [15:0] map_idx = tpmp_pkg::MAP_BASE_INDEX +
                         {14'h0, frame_q};
   tpmp_insert u_ins (
      .acc(acc_q),
      .value(od_value),
      .pos(pos_q),
      .len(cur_len),
      .acc_o(ins_acc)
   );
   // Next-state and flag pulses
   always_comb begin
      state_d = state_q;
      frame_d = frame_q;
      refn_d = refn_q;
      pos_d = pos_q;
      acc_d = acc_q;
      od_req_d = od_req_q;
      od_idx_d = od_idx_q;
      od_sub_d = od_sub_q;
      stat_set = 4'h0;
      case (state_q)
         S_IDLE: begin
            if (trig_valid && trig_rdy_q && ctrl_en_q) begin
               frame_d = trig_frame;
               refn_d = 3'h0;
               pos_d = 7'h00;
               acc_d = 64'h0;
               if (trig_cnt == 8'h00) begin
                  stat_set[tpmp_pkg::ST_SUPP] = 1'b1;
               end else if (trig_cnt > 8'h08) begin
                  stat_set[tpmp_pkg::ST_CNT] = 1'b1;
               end else begin
                  state_d = S_FETCH;
               end
            end
         end
         S_FETCH: begin
            // Slots are used in order, trusting a gapless table
            if (cur_len == 8'h00 ||
                cur_len > tpmp_pkg::MAX_VAL_BITS ||
                end_bit > 8'h40) begin
               stat_set[tpmp_pkg::ST_LEN] = 1'b1;
               state_d = S_IDLE;
            end else begin
               od_req_d = 1'b1;
               od_idx_d = ref_idx(cur_ref);
               od_sub_d = ref_sub(cur_ref);
               state_d = S_WAIT;
            end
         end
         S_WAIT: begin
            if (od_ack) begin
               od_req_d = 1'b0;
               if (!od_mappable) begin
                  stat_set[tpmp_pkg::ST_UNMAP] = 1'b1;
                  state_d = S_IDLE;
               end else begin
                  acc_d = ins_acc;
                  pos_d = end_bit[6:0];
                  refn_d = refn_inc;
                  // Stop at the count, later slots unread
                  state_d = last_ref ? S_PUSH : S_FETCH;
               end
            end
         end
         S_PUSH: begin
            // Waits here while the buffer is full
            if (buf_in_ready) begin
               state_d = S_IDLE;
            end
         end
         default: begin
            state_d = S_IDLE;
         end
      endcase
   end
   // State registers
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         state_q <= S_IDLE;
         frame_q <= 2'h0;
         refn_q <= 3'h0;
         pos_q <= 7'h00;
         acc_q <= 64'h0;
      end else begin
         state_q <= state_d;
         frame_q <= frame_d;
         refn_q <= refn_d;
         pos_q <= pos_d;
         acc_q <= acc_d;
      end
   end
   // Object request and trigger ready registers
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         od_req_q <= 1'b0;
         od_idx_q <= 16'h0;
         od_sub_q <= 8'h00;
         trig_rdy_q <= 1'b0;
      end else begin
         od_req_q <= od_req_d;
         od_idx_q <= od_idx_d;
         od_sub_q <= od_sub_d;
         trig_rdy_q <= (state_d == S_IDLE) && ctrl_en_q;
      end
   end
   // ***************************************************
   // Output buffer
   // ***************************************************
   wire [tpmp_pkg::PAY_W-1:0] buf_in = {frame_q,
                                        dlc_sum[6:3],
                                        map_idx, acc_q};
   logic [tpmp_pkg::PAY_W-1:0] buf_out; // Buffered frame
   tpmp_skid_buf #(
      .W(tpmp_pkg::PAY_W)
   ) u_buf (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .in_valid(state_q == S_PUSH),
      .in_ready(buf_in_ready),
      .in_data(buf_in),
      .out_valid(out_valid),
      .out_ready(out_ready),
      .out_data(buf_out)
   );
   // ***************************************************
   // Output wiring, all from flops
   // ***************************************************
   assign {out_frame, out_dlc, out_map_index, out_data} = buf_out;
   assign av_readdata = rdata_q;
   assign av_waitrequest = wait_q;
   assign trig_ready = trig_rdy_q;
   assign od_req = od_req_q;
   assign od_index = od_idx_q;
   assign od_sub = od_sub_q;
endmodule
`default_nettype wire

//--- bench/tpmp_assertions.sv
// Port checker for the transmit mapping packer
`timescale 1ns/100ps
`default_nettype none
module tpmp_assertions (
   input wire logic core_clk, // Clock
   input wire logic rst_n, // Reset, active low
   input wire logic av_read, // Bus read
   input wire logic av_write, // Bus write
   input wire logic av_waitrequest, // Bus stall
   input wire logic trig_valid, // Send request
   input wire logic trig_ready, // Packer idle
   input wire logic od_req, // Value fetch
   input wire logic [15:0] od_index, // Object index
   input wire logic [7:0] od_sub, // Sub-index
   input wire logic od_ack, // Fetch answer
   input wire logic out_valid, // Frame held
   input wire logic out_ready, // Frame taken
   input wire logic [1:0] out_frame, // Frame number
   input wire logic [15:0] out_map_index, // Table used
   input wire logic [3:0] out_dlc, // Length code
   input wire logic [63:0] out_data // Data field
);
   // *****
   // Checks, all on the one clock
   // *****
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   bus_answer_a: assert property ((av_read || av_write) && av_waitrequest
      |=> !av_waitrequest) else $error("bus access left stalled");
   bus_pulse_a: assert property (!av_waitrequest |=> av_waitrequest)
      else $error("bus answer longer than one cycle");
   fetch_hold_a: assert property (od_req && !od_ack |=> od_req &&
      $stable(od_index) && $stable(od_sub)) else $error("fetch moved");
   fetch_drop_a: assert property (od_req && od_ack |=> !od_req)
      else $error("fetch held after answer");
   trig_take_a: assert property (od_req |-> !trig_ready)
      else $error("request taken while fetching");
   frame_hold_a: assert property (out_valid && !out_ready |=> out_valid &&
      $stable(out_data) && $stable(out_dlc)) else $error("frame dropped");
   table_index_a: assert property (out_valid |->
      out_map_index == 16'h1A00 + {14'h0, out_frame})
      else $error("wrong table index");
   table_range_a: assert property (out_valid |->
      out_map_index >= 16'h1A00 && out_map_index <= 16'h1BFF)
      else $error("table index out of range");
   dlc_range_a: assert property (out_valid |->
      out_dlc inside {[4'h1:4'h8]}) else $error("bad length code");
   dlc_fill_a: assert property (out_valid && out_dlc < 4'h8 |->
      (out_data >> {out_dlc, 3'h0}) == 64'h0) else $error("data past code");
endmodule
bind tpmp_top tpmp_assertions chk_u (.core_clk, .rst_n, .av_read,
   .av_write, .av_waitrequest, .trig_valid, .trig_ready, .od_req,
   .od_index, .od_sub, .od_ack, .out_valid, .out_ready, .out_frame,
   .out_map_index, .out_dlc, .out_data);
`default_nettype wire

//--- bench/tpmp_od_model.sv
// Object store that answers the packer's value fetches
`timescale 1ns/100ps
`default_nettype none
module tpmp_od_model (
   input wire logic core_clk, // Clock
   input wire logic rst_n, // Reset, active low
   input wire logic od_req, // Fetch request
   input wire logic [15:0] od_index, // Object index
   input wire logic [7:0] od_sub, // Sub-index
   input wire logic [2:0] delay, // Wait cycles before answer
   input wire logic [15:0] bad_index, // Object not mappable
   output logic od_ack, // Answer pulse
   output logic [31:0] od_value, // Object value
   output logic od_mappable // Mappable attribute
);
   logic [2:0] wait_q; // Cycles waited
   logic [31:0] noise_q; // Filler, so stale values never match
   // Value held by each object
   function automatic logic [31:0] obj_value(logic [15:0] i, logic [7:0] s);
      return {i ^ 16'hA5C3, s, i[7:0] ^ s};
   endfunction
   // *****
   // Answer after a set delay, once per request
   // *****
   always_ff @(posedge core_clk) begin
      noise_q <= {noise_q[30:0], noise_q[31] ~^ noise_q[21]};
      if (!rst_n) begin
         od_ack <= 1'b0;
         wait_q <= 3'h0;
         noise_q <= 32'h1357_9BDF;
      end else if (od_req && !od_ack && wait_q == delay) begin
         od_ack <= 1'b1;
         wait_q <= 3'h0;
      end else begin
         od_ack <= 1'b0;
         wait_q <= (od_req && !od_ack) ? wait_q + 3'h1 : 3'h0;
      end
   end
   assign od_value = od_ack ? obj_value(od_index, od_sub) : noise_q;
   assign od_mappable = od_ack ? od_index != bad_index : noise_q[3];
endmodule
`default_nettype wire

//--- bench/tpmp_top_tb.sv
// Self-checking bench for the transmit mapping packer
`timescale 1ns/100ps
`default_nettype none
module tpmp_top_tb;
   logic core_clk = 1'b0, rst_n = 1'b0; // Clock and reset
   logic [9:0] av_address = 10'h0; // Bus address
   logic av_read = 1'b0, av_write = 1'b0; // Bus strobes
   logic [31:0] av_writedata = 32'h0, av_readdata, od_value; // Bus data
   logic [3:0] av_byteenable = 4'h0; // Byte lanes
   logic av_waitrequest, trig_ready, od_req, od_ack, od_mappable, out_valid;
   logic trig_valid = 1'b0, out_ready = 1'b0, stall = 1'b0; // Handshakes
   logic [1:0] trig_frame = 2'h0, out_frame; // Frame numbers
   logic [15:0] od_index, out_map_index, bad_index = 16'h7FFF;
   logic [7:0] od_sub; // Fetched sub-index
   logic [2:0] delay = 3'h0; // Fetch answer delay
   logic [3:0] out_dlc; // Length code
   logic [63:0] out_data; // Data field
   logic [85:0] frames[$]; // Frames taken by the sink
   int miscompares = 0, checked = 0, seed = 32'h46F0, sent = 0;
   tpmp_top dut_u (.core_clk, .rst_n, .av_address, .av_read, .av_write,
      .av_writedata, .av_byteenable, .av_readdata, .av_waitrequest,
      .trig_valid, .trig_frame, .trig_ready, .od_req, .od_index, .od_sub,
      .od_ack, .od_value, .od_mappable, .out_valid, .out_ready,
      .out_frame, .out_map_index, .out_dlc, .out_data);
   tpmp_od_model od_u (.core_clk, .rst_n, .od_req, .od_index, .od_sub,
      .delay, .bad_index, .od_ack, .od_value, .od_mappable);
   always #5 core_clk = ~core_clk;
   // Sink stalls at random, or always while stall is set
   always @(posedge core_clk) begin
      out_ready <= !stall && rnd(4) != 0;
      if (out_valid === 1'b1 && out_ready === 1'b1)
         frames.push_back({out_frame, out_map_index, out_dlc, out_data});
   end
   // *****
   // Helpers
   // *****
   function automatic int rnd(int n);
      return $unsigned($random(seed)) % n;
   endfunction
   task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic cmp_frame(input logic [85:0] got, input logic [85:0] exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: %h, expected %h", $time, got, exp);
      end
   endtask
   // One bus access, held until the stall drops
   task automatic bus(input logic [9:0] a, input logic w,
      input logic [31:0] d, output logic [31:0] q);
      int n = 0;
      @(posedge core_clk);
      av_address <= a;
      av_write <= w;
      av_read <= !w;
      av_writedata <= d;
      av_byteenable <= 4'hF;
      do begin
         @(posedge core_clk);
         n++;
      end while (av_waitrequest !== 1'b0 && n < 20);
      q = av_readdata;
      av_read <= 1'b0;
      av_write <= 1'b0;
      if (n >= 20) miscompares++;
   endtask
   task automatic wr(input logic [9:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(a, 1'b1, d, q);
   endtask
   task automatic rd_chk(input logic [9:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(a, 1'b0, 32'h0, q);
      cmp_reg(q, exp);
   endtask
   // Waits for idle; with a request up, idle means it was taken
   task automatic trig(input logic go, input logic [1:0] f);
      int n = 0;
      @(posedge core_clk);
      trig_valid <= go;
      trig_frame <= f;
      do begin
         @(posedge core_clk);
         n++;
      end while (trig_ready !== 1'b1 && n < 900);
      trig_valid <= 1'b0;
      if (n >= 900) miscompares++;
   endtask
   task automatic finish_test;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial begin
      repeat (50000) @(posedge core_clk);
      miscompares++;
      finish_test();
   end
   // *****
   // Main sequence
   // *****
   initial begin
      logic [31:0] refs[8];
      logic [63:0] data, v;
      logic [85:0] exp, got;
      int cnt, pos, len, rem, f, n0;
      repeat (8) @(posedge core_clk);
      rst_n <= 1'b1;
      rd_chk(tpmp_pkg::CTRL_ADDR, 32'h0); // Disabled after reset
      rd_chk(tpmp_pkg::SENT_ADDR, 32'h0);
      rd_chk(10'h08C, 32'h0);
      rd_chk(10'h3F0, 32'h0); // Unmapped place reads zero
      // Count zero, count nine, length 40, length 0, unmappable
      for (int e = 0; e < 5; e++) begin
         wr(tpmp_pkg::CTRL_ADDR, 32'h0);
         wr(10'h0C0, e == 0 ? 0 : e == 1 ? 9 : 1);
         wr(10'h0C4, {16'h6000, 8'h0, e == 2 ? 8'h28 : e == 3 ? 8'h0 :
            8'h10});
         bad_index <= e == 4 ? 16'h6000 : 16'h7FFF;
         wr(tpmp_pkg::CTRL_ADDR, 32'h1);
         n0 = frames.size();
         trig(1'b1, 2'h3);
         trig(1'b0, 2'h3);
         repeat (6) @(posedge core_clk);
         cmp_reg(frames.size(), n0);
         rd_chk(tpmp_pkg::STAT_ADDR, 32'h1 << (4 - e + (e > 2)));
         wr(tpmp_pkg::STAT_ADDR, 32'h1F);
         rd_chk(tpmp_pkg::STAT_ADDR, 32'h0);
      end
      bad_index <= 16'h7FFF;
      // Random tables, the first two forced to full and single
      for (int it = 0; it < 30; it++) begin
         f = rnd(4);
         cnt = it == 0 ? 8 : it == 1 ? 1 : 1 + rnd(8);
         pos = 0;
         for (int k = 0; k < 8; k++) begin
            rem = 64 - pos - (cnt - 1 - k);
            rem = (k >= cnt || rem > 32) ? 32 : rem;
            len = it == 0 ? 8 : it == 1 ? 32 : 1 + rnd(rem);
            pos += k < cnt ? len : 0;
            refs[k] = {k < cnt ? 16'h6000 + 16'(rnd(256)) : bad_index,
               8'(rnd(256)), 8'(len)};
         end
         wr(tpmp_pkg::CTRL_ADDR, 32'h0);
         wr(10'(f * 64), 32'(cnt));
         for (int k = 0; k < 8; k++)
            wr(10'(f * 64 + 4 * k + 4), refs[k]);
         rd_chk(10'(f * 64), 32'(cnt));
         rd_chk(10'(f * 64 + 4), refs[0]);
         wr(tpmp_pkg::CTRL_ADDR, 32'h1);
         delay <= 3'(rnd(8));
         data = 64'h0;
         pos = 0;
         for (int k = 0; k < cnt; k++) begin
            len = refs[k][7:0];
            v = {32'h0, od_u.obj_value(refs[k][31:16], refs[k][15:8])};
            data |= (v & ((64'h1 << len) - 64'h1)) << pos;
            pos += len;
         end
         exp = {2'(f), 16'h1A00 + 16'(f), 4'((pos + 7) / 8), data};
         n0 = it == 29 ? 3 : 1;
         stall <= it == 29;
         for (int t = 0; t < n0; t++)
            trig(1'b1, 2'(f));
         if (it == 29) begin
            repeat (40) @(posedge core_clk);
            cmp_reg({31'h0, trig_ready}, 32'h0); // Full buffer stalls
            stall <= 1'b0;
         end
         for (int t = 0; t < n0; t++) begin
            for (int w = 0; w < 200 && frames.size() == 0; w++)
               @(posedge core_clk);
            got = frames.size() ? frames.pop_front() : 86'h0;
            cmp_frame(got, exp);
            sent++;
         end
      end
      rd_chk(tpmp_pkg::SENT_ADDR, 32'(sent));
      finish_test();
   end
endmodule
`default_nettype wire
